// file: eeprom_pkg.sv
//==============================================================================
// Purpose: Shared constants and types for the serial EEPROM command port.
// Assumes: ref_clk at 100 MHz; link pins are asynchronous to it.
// Notes:   Timing counts are derived from times here; the top may shorten them.
//==============================================================================
package eeprom_pkg;

  //============================================================================
  // Clock and programming times
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int WORD_PROG_MS = 4;
  localparam int ERASE_ALL_MS = 8;
  localparam int FILL_ALL_MS = 16;
  localparam int WORD_PROG_CYCLES = WORD_PROG_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int ERASE_ALL_CYCLES = ERASE_ALL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int FILL_ALL_CYCLES = FILL_ALL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W = 24;

  //============================================================================
  // Geometry (largest variant by default)
  localparam int ADDR_FIELD_X8_DEF = 9;
  localparam int MEM_ADDR_W_DEF = 9;
  localparam int OPCODE_BITS = 2;
  localparam int BYTE_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 5;
  localparam logic [WORD_BITS-1:0] ERASED_WORD = 16'hFFFF;

  //============================================================================
  // Opcodes and subcodes
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;

  //============================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_READ = 2'h3,
    ST_DONE = 2'h2
  } cmd_state_e;

  typedef enum logic [1:0] {
    PK_NONE = 2'h0,
    PK_WORD = 2'h1,
    PK_ERASE_ALL = 2'h2,
    PK_FILL_ALL = 2'h3
  } prog_kind_e;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic din;
  } serial_pins_s;

endpackage : eeprom_pkg

// file: word_fifo.sv
//==============================================================================
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Flush empties it in one cycle and wins over push and pop.
//==============================================================================
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_s;

  fifo_state_s r;
  fifo_state_s n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  //============================================================================
  // Handshakes
  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;
  assign out_data = mem[r.rp];

  // Pointer and fill level update
  always_comb begin
    n = r;
    if (flush) begin
      n = '0;
    end else begin
      if (push) n.wp = r.wp + AW'(1);
      if (pop) n.rp = r.rp + AW'(1);
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) r <= '0;
    else r <= n;
  end

  // Storage needs no reset; words are only read once counted in
  always_ff @(posedge ref_clk) begin
    if (push) mem[r.wp] <= in_data;
  end

endmodule : word_fifo

// file: serial_eeprom_command_port.sv
//==============================================================================
// Purpose: Command port of a three-wire serial EEPROM, array included.
// Assumes: Link pins and organization_select are asynchronous to ref_clk.
// Notes:   Link clock is sampled and its rising edges found on ref_clk.
//==============================================================================
`timescale 1ns/10ps
module serial_eeprom_command_port #(
  parameter int ADDR_FIELD_X8 = eeprom_pkg::ADDR_FIELD_X8_DEF,
  parameter int MEM_ADDR_W = eeprom_pkg::MEM_ADDR_W_DEF,
  parameter int PROG_WORD_CYCLES = eeprom_pkg::WORD_PROG_CYCLES,
  parameter int PROG_ERASE_ALL_CYCLES = eeprom_pkg::ERASE_ALL_CYCLES,
  parameter int PROG_FILL_ALL_CYCLES = eeprom_pkg::FILL_ALL_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link inputs
  input wire eeprom_pkg::serial_pins_s link_pins,
  input wire logic organization_select,
  // Serial data output pin
  output logic dout,
  output logic dout_oe,
  // Status
  output logic standby,
  output logic ready_busy_flag,
  output logic program_enabled
);
  import eeprom_pkg::*;

  localparam int SH_W = OPCODE_BITS + ADDR_FIELD_X8 + WORD_BITS;
  localparam int MEM_BYTES = 1 << MEM_ADDR_W;

  typedef struct packed {
    serial_pins_s sync1;
    serial_pins_s sync2;
    serial_pins_s last;
    logic org1;
    logic org2;
    cmd_state_e st;
    logic [CNT_W-1:0] bitcnt;
    logic [SH_W-1:0] sh;
    prog_kind_e pend;
    logic [MEM_ADDR_W-1:0] paddr;
    logic [WORD_BITS-1:0] pdata;
    logic prog_en;
    logic busy;
    logic [BUSY_CNT_W-1:0] busy_cnt;
    logic status_on;
    logic dout;
    logic oe;
    logic [WORD_BITS-1:0] rd_sh;
    logic [CNT_W-1:0] rd_left;
    logic fetch_on;
    logic [MEM_ADDR_W-1:0] faddr;
  } port_state_s;

  port_state_s r;
  port_state_s n;
  logic [BYTE_BITS-1:0] mem [MEM_BYTES];
  logic cs;
  logic din;
  logic x16;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic [CNT_W-1:0] alen;
  logic [CNT_W-1:0] dlen;
  logic [CNT_W-1:0] addr_end;
  logic [CNT_W-1:0] data_end;
  logic [CNT_W-1:0] bits_in;
  logic [SH_W-1:0] sh_new;
  logic [1:0] op_a;
  logic [1:0] sub_a;
  logic [1:0] op_d;
  logic mem_go;
  logic [MEM_ADDR_W-1:0] faddr_nx1;
  logic [WORD_BITS-1:0] fetch_word;
  logic fifo_in_ready;
  logic fifo_pop;
  logic [WORD_BITS-1:0] fifo_word;

  //============================================================================
  // Helpers
  // Byte address from the address field; the field msb is dropped when
  // the array is smaller than the field allows
  function automatic logic [MEM_ADDR_W-1:0] byte_addr(input logic [SH_W-1:0] v,
                                                      input logic wide);
    if (wide) byte_addr = {v[MEM_ADDR_W-2:0], 1'b0};
    else byte_addr = v[MEM_ADDR_W-1:0];
  endfunction : byte_addr

  function automatic logic [BUSY_CNT_W-1:0] prog_cycles(input prog_kind_e k);
    case (k)
      PK_ERASE_ALL: prog_cycles = BUSY_CNT_W'(PROG_ERASE_ALL_CYCLES);
      PK_FILL_ALL: prog_cycles = BUSY_CNT_W'(PROG_FILL_ALL_CYCLES);
      default: prog_cycles = BUSY_CNT_W'(PROG_WORD_CYCLES);
    endcase
  endfunction : prog_cycles

  //============================================================================
  // Synchronised pins and edges; only the second stage is looked at
  assign cs = r.sync2.sel;
  assign din = r.sync2.din;
  assign x16 = r.org2;
  assign cs_rise = r.sync2.sel && !r.last.sel;
  assign cs_fall = !r.sync2.sel && r.last.sel;
  assign sclk_rise = r.sync2.sclk && !r.last.sclk;

  // Field lengths by organization; address widths give the variant counts
  assign alen = x16 ? CNT_W'(ADDR_FIELD_X8 - 1) : CNT_W'(ADDR_FIELD_X8);
  assign dlen = x16 ? CNT_W'(WORD_BITS) : CNT_W'(BYTE_BITS);
  assign addr_end = CNT_W'(OPCODE_BITS) + alen;
  assign data_end = addr_end + dlen;
  assign bits_in = r.bitcnt + CNT_W'(1);

  // Incoming bits shift in msb first
  assign sh_new = {r.sh[SH_W-2:0], din};
  assign op_a = 2'(sh_new >> alen);
  assign sub_a = 2'(sh_new >> (alen - CNT_W'(OPCODE_BITS)));
  // Opcode sits above the address and data fields at the last data bit
  assign op_d = 2'(sh_new >> (alen + dlen));

  //============================================================================
  // Read prefetch: words stream into the FIFO ahead of the serial clock
  assign faddr_nx1 = r.faddr + MEM_ADDR_W'(1);
  assign fetch_word = x16 ? {mem[r.faddr], mem[faddr_nx1]} : {8'h00, mem[r.faddr]};

  word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .flush(!cs),
    .in_valid(r.fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(fetch_word),
    .out_valid(),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  //============================================================================
  // Command sequencer
  always_comb begin
    n = r;
    mem_go = 1'b0;
    fifo_pop = 1'b0;
    n.sync1 = link_pins;
    n.sync2 = r.sync1;
    n.last = r.sync2;
    n.org1 = organization_select;
    n.org2 = r.org1;

    // Self-timed countdown runs whatever select does
    if (r.busy) begin
      if (r.busy_cnt <= BUSY_CNT_W'(1)) n.busy = 1'b0;
      else n.busy_cnt = r.busy_cnt - BUSY_CNT_W'(1);
    end

    // Stalled prefetch waits for room, so the FIFO really fills
    if (r.fetch_on && fifo_in_ready) begin
      n.faddr = x16 ? r.faddr + MEM_ADDR_W'(2) : faddr_nx1;
    end

    // Falling select launches a complete, enabled erase or write
    if (cs_fall) begin
      if (r.pend != PK_NONE && r.prog_en && !r.busy) begin
        mem_go = 1'b1;
        n.busy = 1'b1;
        n.busy_cnt = prog_cycles(r.pend);
      end
      n.pend = PK_NONE;
    end

    if (!cs) begin
      // Command logic held in reset while deselected
      n.st = ST_IDLE;
      n.bitcnt = '0;
      n.oe = 1'b0;
      n.status_on = 1'b0;
      n.fetch_on = 1'b0;
      n.rd_left = '0;
    end else begin
      // Status shows only if select rises while a cycle runs
      if (cs_rise && r.busy) n.status_on = 1'b1;
      if (sclk_rise) begin
        case (r.st)
          ST_IDLE: begin
            // Busy device keeps showing status instead of taking commands
            if (din && !r.busy) begin
              n.st = ST_SHIFT;
              n.bitcnt = '0;
              n.status_on = 1'b0;
              n.oe = 1'b0;
            end
          end
          ST_SHIFT: begin
            n.sh = sh_new;
            n.bitcnt = bits_in;
            if (bits_in == addr_end) begin
              n.paddr = byte_addr(sh_new, x16);
              n.st = ST_DONE;
              case (op_a)
                OP_READ: begin
                  // Dummy zero goes out on the edge of the last address bit
                  n.st = ST_READ;
                  n.dout = 1'b0;
                  n.oe = 1'b1;
                  n.faddr = byte_addr(sh_new, x16);
                  n.fetch_on = 1'b1;
                  n.rd_left = '0;
                end
                OP_WRITE: n.st = ST_SHIFT;
                OP_ERASE: begin
                  n.pend = PK_WORD;
                  n.pdata = ERASED_WORD;
                end
                default: begin
                  case (sub_a)
                    SUB_ENABLE: n.prog_en = 1'b1;
                    SUB_DISABLE: n.prog_en = 1'b0;
                    SUB_ERASE_ALL: n.pend = PK_ERASE_ALL;
                    default: n.st = ST_SHIFT;
                  endcase
                end
              endcase
            end else if (bits_in == data_end) begin
              // Only now is a data instruction complete
              n.st = ST_DONE;
              n.pdata = x16 ? sh_new[WORD_BITS-1:0] : {8'h00, sh_new[BYTE_BITS-1:0]};
              n.pend = (op_d == OP_WRITE) ? PK_WORD : PK_FILL_ALL;
            end
          end
          ST_READ: begin
            if (r.rd_left == '0) begin
              // Next word boundary: pull a prefetched word
              fifo_pop = 1'b1;
              n.rd_sh = x16 ? fifo_word : {fifo_word[BYTE_BITS-1:0], 8'h00};
              n.dout = n.rd_sh[WORD_BITS-1];
              n.rd_sh = {n.rd_sh[WORD_BITS-2:0], 1'b0};
              n.rd_left = dlen - CNT_W'(1);
            end else begin
              n.dout = r.rd_sh[WORD_BITS-1];
              n.rd_sh = {r.rd_sh[WORD_BITS-2:0], 1'b0};
              n.rd_left = r.rd_left - CNT_W'(1);
            end
          end
          default: begin
            // Finished instruction: clock and data are don't care
            n.st = ST_DONE;
          end
        endcase
      end
    end

    // Status polling level follows the running cycle
    if (n.status_on) begin
      n.oe = 1'b1;
      n.dout = !n.busy;
    end
  end

  // Reset state is all zero: idle, write-disabled, not busy, released
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) r <= '0;
    else r <= n;
  end

  //============================================================================
  // Array update at the start of a programming cycle; fill-all overwrites
  // everything, which covers its built-in erase
  always_ff @(posedge ref_clk) begin
    if (mem_go) begin
      case (r.pend)
        PK_WORD: begin
          if (x16) begin
            mem[r.paddr] <= r.pdata[WORD_BITS-1:BYTE_BITS];
            mem[r.paddr + MEM_ADDR_W'(1)] <= r.pdata[BYTE_BITS-1:0];
          end else begin
            mem[r.paddr] <= r.pdata[BYTE_BITS-1:0];
          end
        end
        PK_ERASE_ALL: begin
          for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= ERASED_WORD[BYTE_BITS-1:0];
          end
        end
        PK_FILL_ALL: begin
          for (int i = 0; i < MEM_BYTES; i++) begin
            if (x16 && i[0] == 1'b0) mem[i] <= r.pdata[WORD_BITS-1:BYTE_BITS];
            else mem[i] <= r.pdata[BYTE_BITS-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  //============================================================================
  // Outputs
  assign dout = r.dout;
  assign dout_oe = r.oe;
  assign standby = !cs && !r.busy;
  assign ready_busy_flag = !r.busy;
  assign program_enabled = r.prog_en;

endmodule : serial_eeprom_command_port

// file: serial_eeprom_command_port_asserts.sv
// Purpose: Port-level checks of the EEPROM command port.
// Assumes: Programming counts equal those of the bound instance.
// Notes: Link pins are sampled raw, so bounds allow for the sync stages.
`timescale 1ns/10ps
module serial_eeprom_command_port_asserts #(
  parameter int PROG_WORD_CYCLES = 20,
  parameter int PROG_ERASE_ALL_CYCLES = 40,
  parameter int PROG_FILL_ALL_CYCLES = 80
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Link side
  input wire eeprom_pkg::serial_pins_s link_pins,
  input wire logic organization_select,
  input wire logic dout,
  input wire logic dout_oe,
  // Status
  input wire logic standby,
  input wire logic ready_busy_flag,
  input wire logic program_enabled
);
  import eeprom_pkg::*;
  int busy_len;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==================
  // Busy stretch length, kept in a counter since it runs to hundreds of cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) busy_len <= 0;
    else if (ready_busy_flag) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end
  // ==================
  // Assertions
  reset_state_a: assert property ($rose(reset_n) |-> !program_enabled && ready_busy_flag)
    else $error("state after reset wrong");
  oe_release_a: assert property ($fell(link_pins.sel) |-> ##[1:5] !dout_oe)
    else $error("data out not released after select fell");
  oe_idle_a: assert property (!link_pins.sel [*6] |-> !dout_oe)
    else $error("data out driven while deselected");
  standby_exit_a: assert property (link_pins.sel [*4] |-> !standby)
    else $error("standby while selected");
  busy_enable_a: assert property ($fell(ready_busy_flag) |-> $past(program_enabled))
    else $error("programming started while disabled");
  status_low_a: assert property ((dout_oe && !ready_busy_flag) [*2] |-> !dout)
    else $error("status not low while busy");
  status_high_a: assert property ($rose(ready_busy_flag) |-> ##[0:2] (dout || !dout_oe))
    else $error("status not high once ready");
  prog_time_a: assert property ($rose(ready_busy_flag) |-> busy_len inside
    {[PROG_WORD_CYCLES-1:PROG_WORD_CYCLES+1], [PROG_ERASE_ALL_CYCLES-1:PROG_ERASE_ALL_CYCLES+1],
     [PROG_FILL_ALL_CYCLES-1:PROG_FILL_ALL_CYCLES+1]})
    else $error("busy time off");
  quiet_sel_a: assert property (!link_pins.sel [*6] |-> $stable(program_enabled))
    else $error("enable changed while deselected");
  // Main scenarios seen
  cov_read_c: cover property (dout_oe && ready_busy_flag && link_pins.sclk);
  cov_busy_c: cover property ($fell(ready_busy_flag));
  cov_en_c: cover property ($rose(program_enabled));
  cov_word_c: cover property (organization_select && dout_oe && ready_busy_flag);
endmodule : serial_eeprom_command_port_asserts

bind serial_eeprom_command_port serial_eeprom_command_port_asserts #(
  .PROG_WORD_CYCLES(PROG_WORD_CYCLES),
  .PROG_ERASE_ALL_CYCLES(PROG_ERASE_ALL_CYCLES),
  .PROG_FILL_ALL_CYCLES(PROG_FILL_ALL_CYCLES)
) u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .link_pins(link_pins),
  .organization_select(organization_select), .dout(dout), .dout_oe(dout_oe),
  .standby(standby), .ready_busy_flag(ready_busy_flag), .program_enabled(program_enabled));

// file: eeprom_link_master.sv
// Purpose: Behavioural serial bus master facing the EEPROM port.
// Assumes: Link clock of 125 ns, unrelated in phase to ref_clk.
// Notes: Clock rests low between frames; stretch slows the low phase.
`timescale 1ns/10ps
module eeprom_link_master (
  // Pins towards the device
  output eeprom_pkg::serial_pins_s link_pins,
  // Resolved data out, separate from din so no dummy-zero clash
  input wire logic dout_line
);
  import eeprom_pkg::*;
  realtime stretch = 0;
  initial link_pins = '0;
  // ==================
  // Clock n bits msb first, catching the data line after each rise
  task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      link_pins.din = bits[i];
      #(62.5 + stretch);
      link_pins.sclk = 1'b1;
      #62.5;
      got = {got[30:0], dout_line};
      link_pins.sclk = 1'b0;
    end
  endtask : shift
  // One instruction; select drops before any further rise
  task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] got);
    link_pins.sel = 1'b1;
    #250;
    shift(bits, n, got);
    link_pins.sel = 1'b0;
    link_pins.din = ~link_pins.din; // Released line must not look held
    #250;
  endtask : frame
  // Select without clocks shows status; wait bounded for ready
  task automatic poll(output logic first, output logic last);
    link_pins.sel = 1'b1;
    #500;
    first = dout_line;
    for (int k = 0; k < 1000 && dout_line !== 1'b1; k++) #10;
    last = dout_line;
    link_pins.sel = 1'b0;
    #250;
  endtask : poll
endmodule : eeprom_link_master

// file: serial_eeprom_command_port_tb_top.sv
// Purpose: Self-checking bench of the EEPROM command port.
// Assumes: Largest variant; short programming counts.
// Notes: Array is written before it is read.
`timescale 1ns/10ps
module serial_eeprom_command_port_tb_top;
  import eeprom_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic organization_select = 1'b0;
  serial_pins_s link_pins;
  logic dout, dout_oe, standby, ready_busy_flag, program_enabled, dout_line;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] got;
  // Clock and pulled-up data line
  always #5 ref_clk = ~ref_clk;
  assign dout_line = dout_oe ? dout : 1'b1;
  serial_eeprom_command_port #(.PROG_WORD_CYCLES(200), .PROG_ERASE_ALL_CYCLES(400),
    .PROG_FILL_ALL_CYCLES(800)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .link_pins(link_pins), .organization_select(organization_select), .dout(dout),
    .dout_oe(dout_oe), .standby(standby), .ready_busy_flag(ready_busy_flag),
    .program_enabled(program_enabled));
  eeprom_link_master u_m (.link_pins(link_pins), .dout_line(dout_line));
  // ==================
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Status poll; a programming run must show busy first
  task automatic wait_ready(input logic busy_exp);
    logic f, l;
    u_m.poll(f, l);
    chk("first_status", {31'h0, ~busy_exp}, {31'h0, f});
    if (l !== 1'b1) begin
      chk("ready_wait", 32'h1, {31'h0, l});
      tally_and_finish();
    end
  endtask : wait_ready
  // ==================
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("enabled", 1'h0, program_enabled);
    chk("ready", 1'h1, ready_busy_flag);
    chk("oe", 1'h0, dout_oe);
    chk("standby", 1'h1, standby);
    $display("test reset done");
    u_m.frame(32'h0, 8, got);
    chk("no_op", 1'h1, ready_busy_flag);
    u_m.frame({3'b100, 8'hC0}, 11, got);
    chk("short_enable", 1'h0, program_enabled);
    u_m.frame({3'b101, 9'h005, 8'h00}, 20, got);
    wait_ready(1'b0);
    u_m.frame({2'b00, 3'b100, 9'h180}, 14, got);
    chk("enable", 1'h1, program_enabled);
    $display("test start done");
    u_m.frame({3'b101, 9'h004, 8'h5A}, 20, got);
    wait_ready(1'b1);
    u_m.stretch = 400;
    u_m.frame({3'b101, 9'h005, 8'hA5}, 20, got);
    u_m.stretch = 0;
    wait_ready(1'b1);
    u_m.frame({3'b101, 9'h005, 6'h00}, 18, got);
    wait_ready(1'b0);
    $display("test write done");
    u_m.frame({3'b110, 9'h005, 8'h00}, 20, got);
    chk("read5", {23'h0, 1'b0, 8'hA5}, {23'h0, got[8:0]});
    chk("oe_off", 1'h0, dout_oe);
    u_m.frame({3'b110, 9'h004, 16'h0}, 28, got);
    chk("seq", {15'h0, 1'b0, 16'h5AA5}, {15'h0, got[16:0]});
    $display("test read done");
    u_m.frame({3'b111, 9'h004}, 12, got);
    wait_ready(1'b1);
    u_m.frame({3'b110, 9'h004, 8'h00}, 20, got);
    chk("erased", {23'h0, 9'h0FF}, {23'h0, got[8:0]});
    u_m.frame({3'b100, 9'h000, 5'h1F}, 17, got);
    chk("disable", 1'h0, program_enabled);
    u_m.frame({3'b101, 9'h005, 8'h00}, 20, got);
    wait_ready(1'b0);
    u_m.frame({3'b110, 9'h005, 8'h00}, 20, got);
    chk("kept", {23'h0, 9'h0A5}, {23'h0, got[8:0]});
    $display("test protect done");
    @(posedge ref_clk);
    organization_select <= 1'b1;
    repeat (5) @(posedge ref_clk);
    u_m.frame({3'b100, 8'hC0}, 11, got);
    chk("enable16", 1'h1, program_enabled);
    u_m.frame({3'b110, 8'h02, 16'h0}, 27, got);
    chk("word2", {15'h0, 1'b0, 16'hFFA5}, {15'h0, got[16:0]});
    u_m.frame({3'b100, 8'h40, 16'h1234}, 27, got);
    wait_ready(1'b1);
    u_m.frame({3'b110, 8'h07, 16'h0}, 27, got);
    chk("filled", {15'h0, 17'h01234}, {15'h0, got[16:0]});
    u_m.frame({3'b100, 8'h80}, 11, got);
    wait_ready(1'b1);
    u_m.frame({3'b110, 8'h00, 16'h0}, 27, got);
    chk("all_ones", {15'h0, 17'h0FFFF}, {15'h0, got[16:0]});
    $display("test word mode done");
    tally_and_finish();
  end
endmodule : serial_eeprom_command_port_tb_top
